// file: sba_adapter.v
`timescale 1ns/1ps
`default_nettype none
`include "sba_regs.vh"

// Functional notes
// - Address and data lines are positive logic: one is the high level.
// - While hold grant is high, address, data, status and command outputs float.
// - Phase-two clock keeps running during hold; it is never tri-stated.
// - Output cycles assert output status with device address; data stable during write strobe.
// - Input cycles assert input status; addressed board drives data-in during data-in strobe.
// - Memory-read status is asserted for every memory read cycle.
// - Wait acknowledge is asserted whenever the processor stopped on low ready request.
// - Status and command float inputs are not implemented; those lines never float by them.
// - Low ready and hold requests stop processor, grant rises until either returns high.
// - Memory write strobe asserted while data-out holds a value for the addressed location.
module sba_adapter (
    input wire mclk_in,
    input wire rstn_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    input wire ready_request_n_in,
    input wire bus_hold_request_n_in,
    input wire power_on_clear_n_in,
    input wire status_float_input_in,
    input wire command_float_input_in,
    input wire [7:0] data_in_in,
    output reg phi2_out,
    output reg [15:0] addr_out,
    output wire addr_oe_out,
    output reg [7:0] data_out_out,
    output wire data_oe_out,
    output reg memory_read_status_out,
    output reg input_cycle_status_out,
    output reg output_cycle_status_out,
    output wire status_oe_out,
    output reg write_strobe_out,
    output reg data_in_strobe_out,
    output reg memory_write_strobe_out,
    output reg wait_acknowledge_out,
    output wire command_oe_out,
    output reg hold_grant_out
);

    // Cycle sequencer states
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_STRB = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_DONE = 3'h4;
    localparam ST_HOLD = 3'h5;

    // Cycle kind decode, shared by status and strobe logic
    function kind_match;
        input [1:0] kind;
        input [1:0] code;
        begin
            kind_match = (kind == code);
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    reg [1:0] rdy_s_r;
    reg [1:0] hld_s_r;
    reg [1:0] poc_s_r;
    reg [7:0] din_m_r;
    reg [7:0] din_s_r;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdy_s_r <= 2'h3;
            hld_s_r <= 2'h3;
            poc_s_r <= 2'h0;
            din_m_r <= 8'h00;
            din_s_r <= 8'h00;
        end else begin
            rdy_s_r <= {rdy_s_r[0], ready_request_n_in};
            hld_s_r <= {hld_s_r[0], bus_hold_request_n_in};
            poc_s_r <= {poc_s_r[0], power_on_clear_n_in};
            din_m_r <= data_in_in;
            din_s_r <= din_m_r;
        end
    end

    // Synchronised pin levels, active low
    wire rdy_n = rdy_s_r[1];
    wire hld_n = hld_s_r[1];
    wire poc_ok = poc_s_r[1];

    // Float inputs are deliberately unused; they never float our lines
    wire unused_float = status_float_input_in | command_float_input_in;

    // ==========================================================
    // Phase-two clock divider, runs through hold
    reg [3:0] phi_cnt_r;
    reg phi_rise;

    // Count half periods; phi2 toggles at the end of each
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phi_cnt_r <= 4'h0;
            phi2_out <= 1'b0;
        end else if (phi_cnt_r == `SBA_PHI_HALF - 4'h1) begin
            phi_cnt_r <= 4'h0;
            phi2_out <= ~phi2_out;
        end else begin
            phi_cnt_r <= phi_cnt_r + 4'h1;
        end
    end

    // One-cycle tick at each falling edge of the bus clock
    always @* begin
        phi_rise = (phi_cnt_r == `SBA_PHI_HALF - 4'h1) && phi2_out;
    end

    // ==========================================================
    // Software registers
    reg [2:0] ctrl_r;
    reg [15:0] addr_r;
    reg [7:0] wdata_r;
    reg [7:0] rdata_r;
    reg [2:0] st_r;
    reg [2:0] st_nxt;
    reg [1:0] kind_r;

    // Busy covers a cycle in flight; hold is not busy
    wire busy = (st_r != ST_IDLE) && (st_r != ST_HOLD);
    wire wr_hit = avs_write_in && (avs_address_in == `SBA_REG_CTRL);
    wire start = wr_hit && avs_writedata_in[`SBA_CTRL_GO] && !busy;

    // ==========================================================
    // Read wait state: one cycle so read data stands when waitrequest drops
    reg rd_valid_r;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= avs_read_in && !rd_valid_r;
        end
    end

    // Writes finish at once; a read waits for its registered data
    assign avs_waitrequest_out = avs_read_in && !rd_valid_r;

    // Register writes; a start loads the cycle kind
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_r <= `SBA_CTRL_RST;
            addr_r <= `SBA_ADDR_RST;
            wdata_r <= `SBA_DATA_RST;
        end else if (avs_write_in) begin
            if (avs_address_in == `SBA_REG_CTRL && !busy) begin
                ctrl_r <= {avs_writedata_in[`SBA_CTRL_KIND_HI:`SBA_CTRL_KIND_LO], 1'b0};
            end
            if (avs_address_in == `SBA_REG_ADDR && !busy) begin
                addr_r <= avs_writedata_in[15:0];
            end
            if (avs_address_in == `SBA_REG_WDATA && !busy) begin
                wdata_r <= avs_writedata_in[7:0];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in) begin
            case (avs_address_in)
                `SBA_REG_CTRL: begin
                    avs_readdata_out <= {24'h000000, rdata_r};
                end
                `SBA_REG_ADDR: begin
                    avs_readdata_out <= {16'h0000, addr_r};
                end
                `SBA_REG_WDATA: begin
                    avs_readdata_out <= {24'h000000, wdata_r};
                end
                `SBA_REG_STAT: begin
                    avs_readdata_out <= {29'h00000000, wait_acknowledge_out,
                                         hold_grant_out, busy};
                end
                default: begin
                    avs_readdata_out <= 32'h00000000;
                end
            endcase
        end else begin
            avs_readdata_out <= 32'h00000000;
        end
    end

    // ==========================================================
    // Bus cycle sequencer
    wire is_read = kind_match(kind_r, `SBA_KIND_MEMRD) || kind_match(kind_r, `SBA_KIND_IORD);
    wire want_hold = !rdy_n && !hld_n;

    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (want_hold)
                    st_nxt = ST_HOLD;
                else if (start)
                    st_nxt = ST_ADDR;
            end
            ST_ADDR: begin
                if (phi_rise)
                    st_nxt = ST_STRB;
            end
            ST_STRB: begin
                if (phi_rise)
                    st_nxt = (is_read && !rdy_n) ? ST_WAIT : ST_DONE;
            end
            ST_WAIT: begin
                if (rdy_n && phi_rise)
                    st_nxt = ST_DONE;
            end
            ST_DONE: begin
                if (phi_rise)
                    st_nxt = ST_IDLE;
            end
            ST_HOLD: begin
                if (rdy_n || hld_n)
                    st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // State, captured data and pin registers
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= ST_IDLE;
            kind_r <= `SBA_KIND_MEMRD;
            rdata_r <= `SBA_DATA_RST;
            addr_out <= `SBA_ADDR_RST;
            data_out_out <= `SBA_DATA_RST;
            memory_read_status_out <= 1'b0;
            input_cycle_status_out <= 1'b0;
            output_cycle_status_out <= 1'b0;
            write_strobe_out <= 1'b0;
            data_in_strobe_out <= 1'b0;
            memory_write_strobe_out <= 1'b0;
            wait_acknowledge_out <= 1'b0;
            hold_grant_out <= 1'b0;
        end else if (!poc_ok) begin
            // Power-on clear returns the processor side to idle
            st_r <= ST_IDLE;
            memory_read_status_out <= 1'b0;
            input_cycle_status_out <= 1'b0;
            output_cycle_status_out <= 1'b0;
            write_strobe_out <= 1'b0;
            data_in_strobe_out <= 1'b0;
            memory_write_strobe_out <= 1'b0;
            wait_acknowledge_out <= 1'b0;
            hold_grant_out <= 1'b0;
        end else begin
            st_r <= st_nxt;

            // Latch address, data and status as a cycle starts
            if (st_r == ST_IDLE && st_nxt == ST_ADDR) begin
                kind_r <= avs_writedata_in[`SBA_CTRL_KIND_HI:`SBA_CTRL_KIND_LO];
                addr_out <= addr_r;
                data_out_out <= wdata_r;
                memory_read_status_out <= kind_match(avs_writedata_in[2:1], `SBA_KIND_MEMRD);
                input_cycle_status_out <= kind_match(avs_writedata_in[2:1], `SBA_KIND_IORD);
                output_cycle_status_out <= kind_match(avs_writedata_in[2:1], `SBA_KIND_IOWR);
            end

            // Write strobes span the strobe state, data-in strobe the strobe and wait states; data-out stays put throughout
            write_strobe_out <= (st_nxt == ST_STRB) && !is_read;
            memory_write_strobe_out <= (st_nxt == ST_STRB) && kind_match(kind_r, `SBA_KIND_MEMWR);
            data_in_strobe_out <= ((st_nxt == ST_STRB) || (st_nxt == ST_WAIT)) && is_read;
            wait_acknowledge_out <= (st_nxt == ST_WAIT) || (st_nxt == ST_HOLD);
            hold_grant_out <= (st_nxt == ST_HOLD);
            // Read data captured at the end of the strobe
            if ((st_r == ST_STRB || st_r == ST_WAIT) && st_nxt == ST_DONE && is_read)
                rdata_r <= din_s_r;

            // Clear status as the cycle ends or the bus is handed over
            if (st_nxt == ST_IDLE || st_nxt == ST_HOLD) begin
                memory_read_status_out <= 1'b0;
                input_cycle_status_out <= 1'b0;
                output_cycle_status_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Output enables: float under hold grant, float inputs ignored
    assign addr_oe_out = !hold_grant_out;
    assign data_oe_out = !hold_grant_out;
    assign status_oe_out = !hold_grant_out || (unused_float & 1'b0);
    assign command_oe_out = !hold_grant_out;

endmodule

`default_nettype wire

// file: sba_regs.vh
`ifndef SBA_REGS_VH
`define SBA_REGS_VH

// ==========================================================
// Register map (Avalon-MM word addresses as byte offsets)
`define SBA_REG_CTRL 4'h0
`define SBA_REG_ADDR 4'h4
`define SBA_REG_WDATA 4'h8
`define SBA_REG_STAT 4'hc
`define SBA_REG_RDATA 4'h0

// ==========================================================
// Control register fields
`define SBA_CTRL_GO 0
`define SBA_CTRL_KIND_LO 1
`define SBA_CTRL_KIND_HI 2

// ==========================================================
// Status register fields
`define SBA_STAT_BUSY 0
`define SBA_STAT_GRANT 1
`define SBA_STAT_WAIT 2

// ==========================================================
// Cycle kinds
`define SBA_KIND_MEMRD 2'h0
`define SBA_KIND_MEMWR 2'h1
`define SBA_KIND_IORD 2'h2
`define SBA_KIND_IOWR 2'h3

// ==========================================================
// Reset values
`define SBA_CTRL_RST 3'h0
`define SBA_ADDR_RST 16'h0000
`define SBA_DATA_RST 8'h00

// ==========================================================
// Timing: bus clock half period in mclk cycles
`define SBA_PHI_HALF 4'h2

`endif

// file: sba_adapter_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sba_adapter_properties (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic ready_request_n_in,
    input wire logic bus_hold_request_n_in,
    input wire logic phi2_out,
    input wire logic [7:0] data_out_out,
    input wire logic addr_oe_out,
    input wire logic data_oe_out,
    input wire logic status_oe_out,
    input wire logic command_oe_out,
    input wire logic memory_read_status_out,
    input wire logic input_cycle_status_out,
    input wire logic output_cycle_status_out,
    input wire logic write_strobe_out,
    input wire logic data_in_strobe_out,
    input wire logic memory_write_strobe_out,
    input wire logic wait_acknowledge_out,
    input wire logic hold_grant_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // ==========================================
    // Bus ownership, clock and strobes
    a_grant_floats_bus: assert property (hold_grant_out |-> !addr_oe_out && !data_oe_out) else $error("bus on");
    a_grant_floats_ctl: assert property (hold_grant_out |-> !status_oe_out && !command_oe_out) else $error("ctl on");
    a_own_drives_ctl: assert property (!hold_grant_out |-> status_oe_out && command_oe_out) else $error("ctl off");
    a_clock_keeps_on: assert property (hold_grant_out && $stable(phi2_out) |=> !$stable(phi2_out)) else $error("clk");
    a_wdata_steady: assert property (write_strobe_out && $past(write_strobe_out) |-> $stable(data_out_out)) else $error("wd");
    a_status_single: assert property ($onehot0({memory_read_status_out, input_cycle_status_out,
        output_cycle_status_out})) else $error("status");
    a_read_has_status: assert property (data_in_strobe_out |-> memory_read_status_out || input_cycle_status_out)
        else $error("rd status");
    a_memwr_is_write: assert property (memory_write_strobe_out |-> write_strobe_out && !output_cycle_status_out)
        else $error("memwr");
    a_wait_ends: assert property (ready_request_n_in [*7] |-> !wait_acknowledge_out) else $error("wait");
    a_grant_ends: assert property (bus_hold_request_n_in [*6] |-> !hold_grant_out) else $error("grant");
endmodule
bind sba_adapter sba_adapter_properties sba_adapter_properties_inst (.mclk_in, .rstn_in, .ready_request_n_in,
    .bus_hold_request_n_in, .phi2_out, .data_out_out, .addr_oe_out, .data_oe_out, .status_oe_out, .command_oe_out,
    .memory_read_status_out, .input_cycle_status_out, .output_cycle_status_out, .write_strobe_out,
    .data_in_strobe_out, .memory_write_strobe_out, .wait_acknowledge_out, .hold_grant_out);
`default_nettype wire

// file: sba_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module sba_board_model (
    input wire logic mclk_in,
    input wire logic stall_in,
    input wire logic dma_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] data_out_in,
    input wire logic write_strobe_in,
    input wire logic data_in_strobe_in,
    output logic [7:0] data_in_out,
    output logic ready_request_n_out,
    output logic bus_hold_request_n_out
);
    logic [7:0] mem_r [0:15];
    logic [7:0] last_r = 8'h00;
    logic [2:0] slow_r = 3'h0;
    // Store written bytes, count read strobe length
    always @(posedge mclk_in) begin
        if (write_strobe_in) mem_r[addr_in[3:0]] <= data_out_in;
        if (data_in_strobe_in) last_r <= mem_r[addr_in[3:0]];
        slow_r <= data_in_strobe_in ? slow_r + 3'h1 : 3'h0;
    end
    // Drive only while strobed, else the inverse of the last byte
    assign data_in_out = data_in_strobe_in ? mem_r[addr_in[3:0]] : ~last_r;
    // Stall reads only; a bus request pulls both lines low
    assign ready_request_n_out = !(dma_in || (stall_in && data_in_strobe_in && slow_r < 3'h4));
    assign bus_hold_request_n_out = !dma_in;
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sba_regs.vh"
module testbench;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic stall = 1'b0;
    logic dma = 1'b0;
    logic seen_wait = 1'b0;
    logic [31:0] q;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    wire [31:0] rdata;
    wire [15:0] addr;
    wire [7:0] dout, din;
    wire waitreq, ready_n, hold_n, phi2, addr_oe, wstb, rstb, wack, grant;
    sba_adapter sba_adapter_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .ready_request_n_in(ready_n),
        .bus_hold_request_n_in(hold_n), .power_on_clear_n_in(1'b1), .status_float_input_in(1'b1),
        .command_float_input_in(1'b1), .data_in_in(din), .phi2_out(phi2), .addr_out(addr), .addr_oe_out(addr_oe),
        .data_out_out(dout), .data_oe_out(), .memory_read_status_out(), .input_cycle_status_out(),
        .output_cycle_status_out(), .status_oe_out(), .write_strobe_out(wstb), .data_in_strobe_out(rstb),
        .memory_write_strobe_out(), .wait_acknowledge_out(wack), .command_oe_out(), .hold_grant_out(grant));
    sba_board_model sba_board_model_inst (.mclk_in(mclk_in), .stall_in(stall), .dma_in(dma), .addr_in(addr),
        .data_out_in(dout), .write_strobe_in(wstb), .data_in_strobe_in(rstb), .data_in_out(din),
        .ready_request_n_out(ready_n), .bus_hold_request_n_out(hold_n));
    always #25 mclk_in = ~mclk_in;
    // Cycle count, wait flag and hang limit
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (wack === 1'b1) seen_wait <= 1'b1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Avalon transfer; n back-to-back beats, last read data kept
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input int n);
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        repeat (n) begin
            @(posedge mclk_in);
            while (waitreq !== 1'b0) @(posedge mclk_in);
            q = rdata;
        end
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic op(input logic [1:0] kind, input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, `SBA_REG_ADDR, {16'h0, a}, 1);
        bus(1'b1, `SBA_REG_WDATA, {24'h0, d}, 1);
        bus(1'b1, `SBA_REG_CTRL, {29'h0, kind, 1'b1}, 1);
        q = 32'h1;
        while (q[`SBA_STAT_BUSY] !== 1'b0) bus(1'b0, `SBA_REG_STAT, 32'h0, 1);
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        bus(1'b0, `SBA_REG_STAT, 32'h0, 1);
        chk(q & 32'h7, 32'h0);
        $display("test reset done");
        op(`SBA_KIND_MEMWR, 16'h8003, 8'ha5);
        op(`SBA_KIND_MEMRD, 16'h8003, 8'h00);
        bus(1'b0, `SBA_REG_RDATA, 32'h0, 1);
        chk(q & 32'hff, 32'ha5);
        $display("test memory done");
        stall <= 1'b1;
        op(`SBA_KIND_IOWR, 16'h0005, 8'h3c);
        op(`SBA_KIND_IORD, 16'h0005, 8'h00);
        bus(1'b0, `SBA_REG_RDATA, 32'h0, 1);
        chk(q & 32'hff, 32'h3c);
        chk({31'h0, seen_wait}, 32'h1);
        stall <= 1'b0;
        $display("test io done");
        dma <= 1'b1;
        repeat (12) @(posedge mclk_in);
        chk({30'h0, grant, addr_oe}, 32'h2);
        q = {31'h0, phi2};
        repeat (2) @(posedge mclk_in);
        chk({31'h0, phi2}, ~q & 32'h1);
        dma <= 1'b0;
        repeat (8) @(posedge mclk_in);
        chk({30'h0, grant, addr_oe}, 32'h1);
        $display("test hold done");
        conclude();
    end
endmodule
`default_nettype wire
